// ==== design/vad_decoder.sv ====
// Virtual area decoder: splits core virtual addresses into areas,
// translates mapped areas through a small software-loaded buffer.
// Assumes a core on the same clock and a classic Wishbone master.
//
// What this block does
// - Takes 32-bit virtual addresses over a 4 GB space split in fixed areas.
// - Translation pages are 1 KB or 4 KB, translated one page at a time.
// - Privileged mode has five areas; low and high mapped areas are paged.
// - Enabled RAM window 7F000000-7FFFFFFF selects on-chip RAM, no translation.
// - Low mapped area writes are write-back or write-through per control reg.
// - Fixed cached area maps directly by clearing address bit 31.
// - Fixed cached area is cacheable when the control reg enables it.
// - Base variant writes fixed cached area through; later variant selects.
// - Fixed uncached area maps directly by clearing bits 31, 30 and 29.
// - Fixed uncached area is never cacheable.
// - Fixed areas skip the translation buffer and never miss.
// - Control space area goes to on-chip control registers.
// - User mode reaches only 00000000-7FFFFFFF, paged.
// - User area has the same on-chip RAM window as the low area.
// - User access at 80000000-FFFFFFFF is blocked with address error.
// - Page rights are set apart for privileged and user; violations flagged.
// - A missing translation raises an exception; software loads the entry.
// - Upper three physical bits are dropped, leaving 29-bit physical space.
// - Mapped areas search the buffer; a hit gives address and page rights.
// - Mode bit zero means user, one means privileged.
module vad_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vad_pkg::vad_req_s req_i,
    output vad_pkg::vad_resp_s resp_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import vad_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_sel

    function automatic logic tlb_hit(input vad_tlb_s e, input logic [31:0] va);
        logic h;
        h = 1'b0;
        if (e.valid) begin
            if (e.size4k) begin
                h = (e.vpn[21:2] == va[31:12]);
            end else begin
                h = (e.vpn == va[31:10]);
            end
        end
        return h;
    endfunction : tlb_hit

    function automatic logic [28:0] tlb_phys(input vad_tlb_s e, input logic [31:0] va);
        logic [28:0] p;
        if (e.size4k) begin
            p = {e.ppn[18:2], va[11:0]};
        end else begin
            p = {e.ppn, va[9:0]};
        end
        return p;
    endfunction : tlb_phys

    // Physical space is 29 bits wide; the top three bits only form shadows
    function automatic logic [28:0] shadow_phys(input logic [31:0] pa);
        return pa[28:0];
    endfunction : shadow_phys

    // Single-lane control writes only count when byte lane 0 is enabled
    function automatic logic lane0_write(input logic wr, input logic [7:0] adr,
                                         input logic [3:0] sel, input logic [7:0] ofs);
        return wr && (adr == ofs) && sel[0];
    endfunction : lane0_write

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [6:0] cache_control_reg;
    logic [2:0] sticky;
    vad_area_e last_area;
    logic [31:0] fault_addr;
    logic [31:0] stage_hi;
    logic [31:0] stage_lo;
    vad_tlb_s tlb [VAD_TLB_ENTRIES];

    logic wb_req;
    logic wb_wr;
    logic ctrl_wr;
    logic status_wr;
    logic load_wr;
    logic [31:0] next_rdata;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign ctrl_wr = lane0_write(wb_wr, wb_adr_i, wb_sel_i, VAD_OFS_CTRL);
    assign status_wr = lane0_write(wb_wr, wb_adr_i, wb_sel_i, VAD_OFS_STATUS);
    assign load_wr = lane0_write(wb_wr, wb_adr_i, wb_sel_i, VAD_OFS_TLB_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // Area decode and translation

    vad_area_e area;
    vad_resp_s next_resp;
    logic [31:0] va;
    logic hit_any;
    logic [28:0] hit_pa;
    logic [2:0] hit_rights;
    logic ram_win;
    logic allowed;
    logic [31:0] fixc_va;
    logic [31:0] fixu_va;

    assign va = req_i.addr;
    assign fixc_va = {1'b0, va[30:0]};
    assign fixu_va = {3'b000, va[28:0]};

    // User mode folds the whole upper half into AREA_USER, the area of its lower half
    always_comb begin
        case (va[31:29])
            VAD_TOP_FIXC: area = AREA_FIXC;
            VAD_TOP_FIXU: area = AREA_FIXU;
            VAD_TOP_HIGH: area = AREA_HIGH;
            VAD_TOP_CTRL: area = AREA_CTRL;
            default: area = req_i.priv ? AREA_LOW : AREA_USER;
        endcase
        if (!req_i.priv && va[31]) begin
            area = AREA_USER;
        end
    end

    // Lowest index wins, so a duplicate load never merges two frames
    always_comb begin
        hit_any = 1'b0;
        hit_pa = '0;
        hit_rights = '0;
        for (int i = 0; i < VAD_TLB_ENTRIES; i++) begin
            if (!hit_any && tlb_hit(tlb[i], va)) begin
                hit_any = 1'b1;
                hit_pa = tlb_phys(tlb[i], va);
                hit_rights = tlb[i].rights;
            end
        end
    end

    // Privileged reads are always allowed; other kinds need their right
    always_comb begin
        if (req_i.priv) begin
            allowed = !req_i.write || hit_rights[VAD_LO_PRIV_WR];
        end else if (req_i.write) begin
            allowed = hit_rights[VAD_LO_USER_WR];
        end else begin
            allowed = hit_rights[VAD_LO_USER_RD];
        end
    end

    assign ram_win = cache_control_reg[VAD_CC_RAM_EN] && (va[31:24] == VAD_RAM_TOP);

    always_comb begin
        next_resp = '0;
        next_resp.valid = req_i.valid;
        // Upper three bits dropped everywhere: shadows alias one location
        next_resp.paddr = shadow_phys(va);
        case (area)
            AREA_FIXC: begin
                next_resp.paddr = shadow_phys(fixc_va);
                next_resp.cacheable = cache_control_reg[VAD_CC_CACHE_FIXED];
                next_resp.write_through = cache_control_reg[VAD_CC_EXT_VARIANT] ?
                    cache_control_reg[VAD_CC_WT_FIXED] : 1'b1;
            end
            AREA_FIXU: begin
                next_resp.paddr = shadow_phys(fixu_va);
                next_resp.cacheable = 1'b0;
            end
            AREA_CTRL: begin
                next_resp.ctrl_space = 1'b1;
            end
            default: begin
                if (!req_i.priv && va[31]) begin
                    next_resp.addr_err = 1'b1;
                end else if (ram_win && area != AREA_HIGH) begin
                    // High mapped area never opens the RAM window
                    next_resp.onchip_ram = 1'b1;
                end else begin
                    next_resp.cacheable = cache_control_reg[VAD_CC_CACHE_MAPPED];
                    next_resp.write_through = cache_control_reg[VAD_CC_WT_MAPPED];
                    if (cache_control_reg[VAD_CC_MMU_EN]) begin
                        // A refused access must never allocate a cache line
                        if (!hit_any) begin
                            next_resp.tlb_miss = 1'b1;
                            next_resp.cacheable = 1'b0;
                        end else if (!allowed) begin
                            next_resp.prot_err = 1'b1;
                            next_resp.cacheable = 1'b0;
                        end else begin
                            next_resp.paddr = hit_pa;
                        end
                    end
                end
            end
        endcase
        if (!req_i.valid) begin
            next_resp = '0;
        end
    end

    // One-cycle answer, one per request cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_o <= '0;
        end else begin
            resp_o <= next_resp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault record: set by hardware, write-one-to-clear, set wins

    logic [2:0] fault_set;
    assign fault_set = {next_resp.prot_err, next_resp.tlb_miss, next_resp.addr_err};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky <= '0;
        end else begin
            if (status_wr) begin
                sticky <= (sticky & ~wb_dat_i[2:0]) | fault_set;
            end else begin
                sticky <= sticky | fault_set;
            end
        end
    end

    // Faulting address kept so the miss handler can refill the entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_addr <= '0;
        end else if (req_i.valid && |fault_set) begin
            fault_addr <= va;
        end
    end

    // Area of the latest request, shown in the status word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_area <= AREA_LOW;
        end else if (req_i.valid) begin
            last_area <= area;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and translation buffer loading

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cache_control_reg <= VAD_CC_RESET;
        end else if (ctrl_wr) begin
            cache_control_reg <= wb_dat_i[6:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_hi <= '0;
        end else if (wb_wr && wb_adr_i == VAD_OFS_TLB_HI) begin
            stage_hi <= merge_sel(stage_hi, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_lo <= '0;
        end else if (wb_wr && wb_adr_i == VAD_OFS_TLB_LO) begin
            stage_lo <= merge_sel(stage_lo, wb_dat_i, wb_sel_i);
        end
    end

    // Entries only change by software load; reset empties them all
    // A reload is seen by the request of the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < VAD_TLB_ENTRIES; i++) begin
                tlb[i] <= '0;
            end
        end else if (load_wr) begin
            tlb[wb_dat_i[1:0]] <= '{
                valid: stage_hi[VAD_HI_VALID],
                size4k: stage_hi[VAD_HI_SIZE4K],
                vpn: stage_hi[31:10],
                ppn: stage_lo[28:10],
                rights: stage_lo[2:0]
            };
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone read mux and acknowledge

    always_comb begin
        next_rdata = '0;
        case (wb_adr_i)
            VAD_OFS_CTRL: next_rdata = {25'h0, cache_control_reg};
            VAD_OFS_STATUS: next_rdata = {21'h0, last_area, 5'h0, sticky};
            VAD_OFS_FAULT: next_rdata = fault_addr;
            VAD_OFS_TLB_HI: next_rdata = stage_hi;
            VAD_OFS_TLB_LO: next_rdata = stage_lo;
            default: next_rdata = '0;
        endcase
    end

    // Unmapped offsets still acknowledge so a stray access never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data only stands beside the acknowledge, zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else begin
            wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0;
        end
    end

endmodule : vad_decoder

// ==== inc/vad_pkg.sv ====
// Package of the virtual area decoder: register map, field positions,
// reset values and the core request/answer carriers.
// Assumes one 25 MHz clock shared by the core, the decoder and Wishbone.
package vad_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] VAD_OFS_CTRL = 8'h00;
    localparam logic [7:0] VAD_OFS_STATUS = 8'h04;
    localparam logic [7:0] VAD_OFS_FAULT = 8'h08;
    localparam logic [7:0] VAD_OFS_TLB_HI = 8'h0c;
    localparam logic [7:0] VAD_OFS_TLB_LO = 8'h10;
    localparam logic [7:0] VAD_OFS_TLB_LOAD = 8'h14;

    // cache_control_reg fields
    localparam int VAD_CC_RAM_EN = 0;
    localparam int VAD_CC_CACHE_MAPPED = 1;
    localparam int VAD_CC_CACHE_FIXED = 2;
    localparam int VAD_CC_WT_MAPPED = 3;
    localparam int VAD_CC_WT_FIXED = 4;
    localparam int VAD_CC_EXT_VARIANT = 5;
    localparam int VAD_CC_MMU_EN = 6;
    localparam logic [6:0] VAD_CC_RESET = 7'h00;

    // Status fields: sticky flags, then last area code
    localparam int VAD_ST_ADDR_ERR = 0;
    localparam int VAD_ST_TLB_MISS = 1;
    localparam int VAD_ST_PROT_ERR = 2;
    localparam int VAD_ST_AREA_LSB = 8;

    // Translation entry staging fields
    localparam int VAD_HI_VALID = 0;
    localparam int VAD_HI_SIZE4K = 1;
    localparam int VAD_LO_PRIV_WR = 0;
    localparam int VAD_LO_USER_RD = 1;
    localparam int VAD_LO_USER_WR = 2;
    localparam int VAD_TLB_ENTRIES = 4;

    // Area boundaries, taken from virtual address bits 31..29
    localparam logic [2:0] VAD_TOP_FIXC = 3'h4;
    localparam logic [2:0] VAD_TOP_FIXU = 3'h5;
    localparam logic [2:0] VAD_TOP_HIGH = 3'h6;
    localparam logic [2:0] VAD_TOP_CTRL = 3'h7;
    localparam logic [7:0] VAD_RAM_TOP = 8'h7f;

    typedef enum logic [2:0] {
        AREA_LOW = 3'b000,
        AREA_FIXC = 3'b001,
        AREA_FIXU = 3'b010,
        AREA_HIGH = 3'b011,
        AREA_CTRL = 3'b100,
        AREA_USER = 3'b101
    } vad_area_e;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic priv;
    } vad_req_s;

    typedef struct packed {
        logic valid;
        logic [28:0] paddr;
        logic cacheable;
        logic write_through;
        logic onchip_ram;
        logic ctrl_space;
        logic addr_err;
        logic tlb_miss;
        logic prot_err;
    } vad_resp_s;

    typedef struct packed {
        logic valid;
        logic size4k;
        logic [21:0] vpn;
        logic [18:0] ppn;
        logic [2:0] rights;
    } vad_tlb_s;

endpackage : vad_pkg

// ==== bench/vad_core_model.sv ====
// Core stand-in: turns one-cycle launch strobes into core requests.
// Assumes the bench drives the launch inputs just after rising edges.
module vad_core_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic write_i,
    input wire logic priv_i,
    output vad_pkg::vad_req_s req_o
);
    import vad_pkg::*;
    initial req_o = '0;
    // Idle fields flip, so a stale request never looks held
    always @(posedge clk_i) begin
        req_o.valid <= go_i;
        req_o.addr <= go_i ? addr_i : ~addr_i;
        req_o.write <= go_i ? write_i : ~write_i;
        req_o.priv <= go_i ? priv_i : ~priv_i;
    end
endmodule : vad_core_model

// ==== bench/vad_decoder_chk.sv ====
// Checker for the area decoder: watches core and Wishbone ports.
// Assumes one clock and a synchronous active-high reset.
module vad_decoder_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vad_pkg::vad_req_s req_i,
    input wire vad_pkg::vad_resp_s resp_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    import vad_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic pv = req_i.valid && req_i.priv;
    wire logic [2:0] top = req_i.addr[31:29];
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ANSWER: assert property (req_i.valid |=> resp_o.valid)
        else $error("answer missing");
    AST_USER_HIGH: assert property (req_i.valid && !req_i.priv && req_i.addr[31]
        |=> resp_o.addr_err && !resp_o.cacheable && !resp_o.onchip_ram)
        else $error("user high access not refused");
    AST_PRIV_OK: assert property (pv |=> !resp_o.addr_err)
        else $error("privileged access refused");
    AST_FIXC: assert property (pv && top == VAD_TOP_FIXC
        |=> resp_o.paddr == $past(req_i.addr[28:0]) && !resp_o.tlb_miss)
        else $error("fixed cached map wrong");
    AST_FIXU: assert property (pv && top == VAD_TOP_FIXU
        |=> resp_o.paddr == $past(req_i.addr[28:0]) && !resp_o.cacheable && !resp_o.tlb_miss)
        else $error("fixed uncached map wrong");
    AST_CTRL: assert property (pv && top == VAD_TOP_CTRL
        |=> resp_o.ctrl_space && !resp_o.cacheable)
        else $error("control space not flagged");
    AST_RAM: assert property (resp_o.onchip_ram
        |-> !resp_o.tlb_miss && !resp_o.cacheable && resp_o.paddr[28:24] == 5'h1f)
        else $error("ram window answer wrong");
    AST_MISS: assert property (resp_o.tlb_miss |-> !resp_o.cacheable && !resp_o.addr_err)
        else $error("miss answer wrong");
    AST_WB_ACK: assert property (s_wb_req |=> s_ack_pulse)
        else $error("ack not a one-cycle pulse");
endmodule : vad_decoder_chk

bind vad_decoder vad_decoder_chk vad_decoder_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .resp_o(resp_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o));

// ==== bench/vad_decoder_tb.sv ====
// Bench for the area decoder: core model, Wishbone tasks, reference model.
// Assumes the decoder answers one cycle after each request.
module vad_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vad_pkg::*;
    logic clk_i = 0, rst_i = 1, go = 0, wr = 0, pv = 0, cyc = 0, stb = 0, we = 0, ack;
    logic [31:0] va = 0, wdat = 0, rd, wbo, seed = 32'h211e, cc = 0;
    logic [31:0] hi[4] = '{default: 0}, lo[4] = '{default: 0}, addrs[4];
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    vad_req_s req;
    vad_resp_s resp;
    int fail_count = 0, check_count = 0;
    vad_core_model vad_core_model_i (.clk_i(clk_i), .go_i(go), .addr_i(va), .write_i(wr),
        .priv_i(pv), .req_o(req));
    vad_decoder vad_decoder_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .resp_o(resp),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wbo), .wb_ack_o(ack));
    initial forever #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = wbo;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic tlb(input int i, input logic [31:0] h, input logic [31:0] l);
        hi[i] = h;
        lo[i] = l;
        wb(1, VAD_OFS_TLB_HI, h);
        wb(1, VAD_OFS_TLB_LO, l);
        wb(1, VAD_OFS_TLB_LOAD, 32'(i));
    endtask : tlb
    // Mask hides fields left open for an answer kind
    function automatic void model(input logic [31:0] a, input logic w, input logic p,
            output vad_resp_s e, output vad_resp_s m);
        int hit;
        e = '0;
        m = '1;
        hit = -1;
        e.valid = 1;
        e.paddr = a[28:0];
        if (!p && a[31]) begin
            e.addr_err = 1;
        end else if (a[31:29] == VAD_TOP_FIXC) begin
            e.cacheable = cc[2];
            e.write_through = cc[5] ? cc[4] : 1'b1;
        end else if (a[31:29] == VAD_TOP_FIXU) begin
            m.write_through = 0;
        end else if (a[31:29] == VAD_TOP_CTRL) begin
            e.ctrl_space = 1;
            m.paddr = '0;
            m.write_through = 0;
        end else if (a[31:29] != VAD_TOP_HIGH && cc[0] && a[31:24] == VAD_RAM_TOP) begin
            e.onchip_ram = 1;
            m.write_through = 0;
        end else begin
            e.cacheable = cc[1];
            e.write_through = cc[3];
            for (int i = 3; i >= 0; i--) begin
                if (hi[i][0] && (hi[i][1] ? hi[i][31:12] == a[31:12] : hi[i][31:10] == a[31:10]))
                    hit = i;
            end
            if (cc[6] && (hit < 0 || !(p ? (!w || lo[hit][0]) : lo[hit][w ? 2 : 1]))) begin
                e.tlb_miss = hit < 0;
                e.prot_err = hit >= 0;
                e.cacheable = 0;
                m.paddr = '0;
            end else if (cc[6]) begin
                e.paddr = hi[hit][1] ? {lo[hit][28:12], a[11:0]} : {lo[hit][28:10], a[9:0]};
            end
        end
    endfunction : model
    task automatic req_chk(input logic [31:0] a, input logic w, input logic p);
        vad_resp_s e, m;
        model(a, w, p, e, m);
        @(posedge clk_i);
        {go, va, wr, pv} <= {1'b1, a, w, p};
        @(posedge clk_i);
        go <= 0;
        @(posedge clk_i);
        @(negedge clk_i);
        check(64'(resp & m), 64'(e & m));
    endtask : req_chk
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end
    initial begin
        logic [31:0] a;
        logic [31:0] r;
        logic [6:0] ccs[5] = '{7'h00, 7'h07, 7'h3f, 7'h1e, 7'h61};
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        foreach (addrs[i]) begin
            wb(0, 8'(4 * i), 0);
            check(rd, 0);
        end
        foreach (ccs[c]) begin
            cc = 32'(ccs[c]);
            wb(1, VAD_OFS_CTRL, cc);
            for (int k = 0; k < 64; k++) begin
                a = rnd();
                a[31:29] = 3'(k);
                if (k[4:3] == 2'b11)
                    a[31:24] = VAD_RAM_TOP;
                r = rnd();
                req_chk(a, r[0], r[1]);
            end
        end
        cc = 32'h4a;
        wb(1, VAD_OFS_CTRL, cc);
        tlb(0, 32'h00400003, 32'h01234003);
        tlb(1, 32'hc0001c01, 32'h00abcc00);
        tlb(2, 32'h00400003, 32'h05550007);
        addrs = '{32'h00400abc, 32'hc0001d23, 32'h12345678, 32'h00400fff};
        foreach (addrs[i]) begin
            for (int j = 0; j < 4; j++)
                req_chk(addrs[i], j[0], j[1]);
        end
        req_chk(32'hc0001234, 0, 0);
        wb(0, VAD_OFS_STATUS, 0);
        check(rd & 32'h701, 32'h501);
        wb(1, VAD_OFS_FAULT, 0);
        wb(0, VAD_OFS_FAULT, 0);
        check(rd, 32'hc0001234);
        wb(1, VAD_OFS_STATUS, 7);
        wb(0, VAD_OFS_STATUS, 0);
        check(rd & 7, 0);
        wrap_up();
    end
endmodule : vad_decoder_tb
